// >>> hw/ssc_master.sv
// serial master: queues bytes and shifts them out, then strobes
`timescale 1ns/100ps
module ssc_master
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // user side
  input  wire logic       wr_valid,
  output logic            wr_ready,
  input  wire logic [7:0] wr_data,
  input  wire logic       commit,
  output logic            busy,
  // link
  ssc_link_if.master      link
);
  typedef enum {M_IDLE, M_LOW, M_HIGH, M_STROBE, M_END} ssc_mstate_t;
  ssc_mstate_t      st_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0]       sh_q;
  logic [2:0]       bit_q;
  logic             pend_q;
  logic             sdata_q;
  logic             sclk_q;
  logic             strobe_q;
  logic             gate_q;
  logic             f_valid;
  logic             f_ready;
  logic [7:0]       f_data;
  logic             tick;

  ssc_fifo #(.WIDTH(UNIT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign tick    = (div_q == DIV_W'(SCK_DIV - 1));
  assign f_ready = (st_q == M_IDLE) && f_valid;
  assign busy    = (st_q != M_IDLE) || f_valid || pend_q;
  assign link.sdata       = sdata_q;
  assign link.sclk        = sclk_q;
  assign link.load_strobe = strobe_q;
  assign link.input_gate  = gate_q;

  // commit request remembered until the master reaches M_STROBE, after all queued bytes are out
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
    end else if (commit) begin
      pend_q <= 1'b1;
    end else if (st_q == M_STROBE) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
    end else if (st_q == M_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // msb first; first byte sent reaches the far unit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= M_IDLE;
      sh_q     <= SR_RESET;
      bit_q    <= '0;
      sdata_q  <= 1'b0;
      sclk_q   <= 1'b0;
      strobe_q <= 1'b0;
      gate_q   <= 1'b0;
    end else begin
      case (st_q)
        M_IDLE: begin
          sclk_q <= 1'b0;
          if (f_valid) begin
            sh_q    <= f_data;
            bit_q   <= '0;
            gate_q  <= 1'b1;
            st_q    <= M_LOW;
          end else if (pend_q) begin
            gate_q <= 1'b1;
            st_q   <= M_STROBE;
          end else begin
            gate_q <= 1'b0;
          end
        end
        M_LOW: begin
          sdata_q <= sh_q[UNIT_BITS-1];
          if (tick) begin
            sclk_q <= 1'b1;
            st_q   <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (tick) begin
            sclk_q <= 1'b0;
            sh_q   <= {sh_q[UNIT_BITS-2:0], 1'b0};
            bit_q  <= bit_q + 1'b1;
            st_q   <= (bit_q == 3'(UNIT_BITS - 1)) ? M_IDLE : M_LOW;
          end
        end
        M_STROBE: begin
          strobe_q <= 1'b1;
          if (tick) begin
            st_q <= M_END;
          end
        end
        M_END: begin
          strobe_q <= 1'b0;
          if (tick) begin
            st_q <= M_IDLE;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end
endmodule

// >>> hw/ssc_pkg.sv
// constants shared by both ends of the serial switch control chain
// Summary of operation
// - 8-bit shift register feeding a transparent latch
// - data, clock, load strobe plus input gate
// - two state bits; both zero disconnects all
// - lo bit selects port one, hi port two
// - eight bits per unit, two low used
// - gate high: inputs act normally
// - gate low: inputs ignored, chain outputs low, switch state held
// - master keeps gate low while idle
// - strobe high: latch follows shift register
// - strobe low: shifting continues, state held
// - master shifts, then pulses strobe once
// - serial out chains up to 30 units
// - master sends eight bits per unit
// - first group ends in last unit
// - chain: all data before single strobe
// - strobe buffered to downstream output
// - gate passed through unbuffered downstream
// - downstream port only forwards, never controls
// - data sampled on serial clock rising edge
package ssc_pkg;
  localparam int UNIT_BITS   = 8;
  localparam int STATE_BITS  = 2;
  localparam int MAX_UNITS   = 30;
  localparam int STATE_LO    = 0;
  localparam int STATE_HI    = 1;
  localparam int SCK_DIV     = 8;
  localparam int DIV_W       = 4;
  localparam int FIFO_DEPTH  = 8;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [1:0] ST_OFF   = 2'h0;
  localparam logic [1:0] ST_ONE   = 2'h1;
  localparam logic [1:0] ST_TWO   = 2'h2;
endpackage

// >>> hw/ssc_link_if.sv
// serial link between master and switch unit
`timescale 1ns/100ps
interface ssc_link_if;
  logic sdata;
  logic sclk;
  logic load_strobe;
  logic input_gate;
  modport master (output sdata, output sclk, output load_strobe,
                  output input_gate);
  modport unit (input sdata, input sclk, input load_strobe,
                input input_gate);
endinterface

// >>> hw/ssc_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/100ps
module ssc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> hw/ssc_unit.sv
// switch unit: shift register, latch, state decode, chain outputs
`timescale 1ns/100ps
module ssc_unit
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // upstream link
  ssc_link_if.unit  link,
  // downstream chain outputs
  output logic      sdata_downstream,
  output logic      sclk_downstream,
  output logic      load_strobe_downstream,
  output logic      input_gate_downstream,
  // switch path drive
  output logic      rf_port_one,
  output logic      rf_port_two,
  output logic [1:0] switch_state
);
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic       sclk_d1_q;
  logic [7:0] sr_q;
  logic [1:0] latch_q;
  logic       gate;
  logic       rise;

  // two-flop synchronisers for data, clock, strobe, gate
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {link.input_gate, link.load_strobe, link.sclk, link.sdata};
      s2_q <= s1_q;
    end
  end

  assign gate = s2_q[3];
  assign rise = s2_q[1] && !sclk_d1_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d1_q <= 1'b0;
    end else begin
      sclk_d1_q <= s2_q[1];
    end
  end

  // shift on rising edge while gated on, regardless of strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_q <= SR_RESET;
    end else if (gate && rise) begin
      sr_q <= {sr_q[UNIT_BITS-2:0], s2_q[0]};
    end
  end

  // latch follows the low two bits while strobe high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= ST_OFF;
    end else if (gate && s2_q[2]) begin
      latch_q <= sr_q[STATE_BITS-1:0];
    end
  end

  assign switch_state = latch_q;
  // both bits set is undefined; treat as disconnected
  assign rf_port_one = (latch_q == ST_ONE);
  assign rf_port_two = (latch_q == ST_TWO);

  // data, clock and strobe chain outputs forced low when gated off; gate passes through
  assign sdata_downstream       = gate & sr_q[UNIT_BITS-1];
  assign sclk_downstream        = gate & s2_q[1];
  assign load_strobe_downstream = gate & s2_q[2];
  assign input_gate_downstream  = link.input_gate;
endmodule

// >>> dv/ssc_link_assertions.sv
// link protocol checks for the serial switch chain
`timescale 1ns/100ps
module ssc_link_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // link
  input wire logic sdata,
  input wire logic sclk,
  input wire logic load_strobe,
  input wire logic input_gate
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  a_idle_clk_low: assert property (!input_gate |-> !sclk)
    else $error("serial clock moves with gate low");
  a_clk_high_len: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("serial clock high time off");
  a_clk_low_len: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("serial clock low time short");
  a_data_stable: assert property (sclk && $past(sclk) |->
    $stable(sdata))
    else $error("data moved while clock high");
  a_gate_lead: assert property ($rose(sclk) |-> $past(input_gate, 8))
    else $error("clock without gate lead");
  a_strobe_len: assert property ($rose(load_strobe) |->
    load_strobe[*8] ##1 !load_strobe)
    else $error("strobe pulse length off");
  a_strobe_gated: assert property (load_strobe |-> input_gate && !sclk)
    else $error("strobe outside gate or with clock");
  a_gate_release: assert property ($fell(load_strobe) |->
    ##[1:20] !input_gate)
    else $error("gate not released after strobe");
  c_strobe: cover property ($rose(load_strobe));
  c_shift: cover property ($rose(sclk));
  c_gate_off: cover property ($fell(input_gate));
endmodule

// >>> dv/tb_top.sv
// two chained units driven by the serial master
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  import ssc_pkg::*;
  logic       core_clk, arst_n, wr_valid, commit, wr_ready, busy;
  logic [7:0] wr_data, va, vb, pa, pb;
  logic       one_a, two_a, one_b, two_b, sd_a, sc_a, ls_a, ig_a;
  logic [1:0] st_a, st_b;
  int         fail_count, checks, stalls, seen, lowc;
  ssc_link_if i_link ();
  ssc_link_if i_link_b ();
  ssc_master i_ssc_master (.core_clk, .arst_n, .wr_valid, .wr_ready,
    .wr_data, .commit, .busy, .link(i_link));
  ssc_unit i_ssc_unit (.core_clk, .arst_n, .link(i_link),
    .sdata_downstream(sd_a), .sclk_downstream(sc_a),
    .load_strobe_downstream(ls_a), .input_gate_downstream(ig_a),
    .rf_port_one(one_a), .rf_port_two(two_a), .switch_state(st_a));
  assign i_link_b.sdata = sd_a;
  assign i_link_b.sclk = sc_a;
  assign i_link_b.load_strobe = ls_a;
  assign i_link_b.input_gate = ig_a;
  ssc_unit i_ssc_unit_b (.core_clk, .arst_n, .link(i_link_b),
    .sdata_downstream(), .sclk_downstream(), .load_strobe_downstream(),
    .input_gate_downstream(), .rf_port_one(one_b), .rf_port_two(two_b),
    .switch_state(st_b));
  ssc_link_assertions i_ssc_link_assertions (.core_clk, .arst_n,
    .sdata(i_link.sdata), .sclk(i_link.sclk),
    .load_strobe(i_link.load_strobe), .input_gate(i_link.input_gate));
  function automatic logic [3:0] expect_out(logic [7:0] b);
    return {b[1:0], b[1:0] == ST_ONE, b[1:0] == ST_TWO};
  endfunction
  task automatic complete_run();
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watch chain outputs while time passes
  task automatic tick(int n);
    repeat (n) begin
      @(negedge core_clk);
      `CHK("gate_pass", i_link.input_gate, ig_a)
      if (ls_a === 1'b1) seen = 1;
      if (i_link.input_gate === 1'b1) lowc = 0;
      else lowc++;
      if (lowc > 4) `CHK("down_low", 3'h0, {sd_a, sc_a, ls_a})
    end
  endtask
  task automatic push(logic [7:0] b);
    int n;
    @(posedge core_clk);
    wr_valid <= 1'b1;
    wr_data <= b;
    n = 0;
    do begin
      tick(1);
      n++;
      if (wr_ready !== 1'b1) stalls++;
    end while (wr_ready !== 1'b1 && n < 5000);
    if (n >= 5000) begin fail_count++; complete_run(); end
    @(posedge core_clk);
    wr_valid <= 1'b0;
  endtask
  task automatic finish_load(bit strobe);
    int n;
    @(posedge core_clk);
    commit <= strobe;
    @(posedge core_clk);
    commit <= 1'b0;
    tick(4);
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin tick(1); n++; end
    if (n >= 5000) begin fail_count++; complete_run(); end
    tick(8);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    arst_n = 1'b0;
    wr_valid = 1'b0;
    commit = 1'b0;
    wr_data = 8'h00;
    void'($urandom(67));
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    tick(2);
    `CHK("reset_out", 4'h0, {st_a, one_a, two_a})
    for (int i = 0; i < 8; i++) begin
      va = 8'($urandom());
      vb = 8'($urandom());
      va[1:0] = 2'(i);
      vb[1:0] = ~2'(i);
      push(vb);
      push(va);
      seen = 0;
      finish_load(1'b1);
      `CHK("unit_a", expect_out(va), {st_a, one_a, two_a})
      `CHK("unit_b", expect_out(vb), {st_b, one_b, two_b})
      `CHK("strobe_down", 1, seen)
    end
    pa = va;
    pb = vb;
    vb = 8'($urandom());
    va = 8'($urandom());
    push(vb);
    push(va);
    finish_load(1'b0);
    `CHK("held_a", expect_out(pa), {st_a, one_a, two_a})
    `CHK("held_b", expect_out(pb), {st_b, one_b, two_b})
    finish_load(1'b1);
    `CHK("late_a", expect_out(va), {st_a, one_a, two_a})
    `CHK("late_b", expect_out(vb), {st_b, one_b, two_b})
    stalls = 0;
    for (int i = 0; i < 10; i++) begin
      vb = va;
      va = 8'($urandom());
      push(va);
    end
    finish_load(1'b1);
    `CHK("fifo_full", 1'b1, stalls > 0)
    `CHK("deep_a", expect_out(va), {st_a, one_a, two_a})
    `CHK("deep_b", expect_out(vb), {st_b, one_b, two_b})
    complete_run();
  end
endmodule
